/* File: hw/tmr0_pkg.sv */
// Package for the 8-bit timer0 register block: offsets, fields, reset values, types
// How it works
// R1: Overflow request needs enable, global enable, flag.
// R2: Decode data offset and offset minus 0x20.
// R3: Software uses load/store above 0x60 only.
// R4: Hold mode keeps prescaler reset bits asserted.
// R5: Clearing hold mode clears both prescaler resets; the code clears the async one with the write, the sync one a cycle later.
// R6: Prescaler reset self-clears unless hold mode set.
// R7: Counter read/write; write blocks next compare match.
// R8: Compare A matched continuously, drives output A.
// R9: Compare B matched continuously, drives output B.
// R10: Flag B sets on match, clears by vector/one.
// R11: Flag A sets on match, clears by vector/one.
// R12: Overflow flag sets on overflow, clears likewise.
// R13: Compare B request needs global, enable, flag.
// R14: Compare A request needs global, enable, flag.
// R15: Overflow point depends on waveform mode.
// R16: Overflow at BOTTOM modes 1,5; TOP 7; MAX 0,2,3.
// R17: Mask bits: B bit2, A bit1, reset zero.
// R18: Zero write keeps flag; set beats clear.
// R19: Unused bits read zero, ignore writes.
package tmr0_pkg;
  localparam logic [7:0] ADR_FLAGS    = 8'h35;
  localparam logic [7:0] ADR_GTCTRL   = 8'h43;
  localparam logic [7:0] ADR_CTRL_A   = 8'h44;
  localparam logic [7:0] ADR_CTRL_B   = 8'h45;
  localparam logic [7:0] ADR_COUNT    = 8'h46;
  localparam logic [7:0] ADR_CMP_A    = 8'h47;
  localparam logic [7:0] ADR_CMP_B    = 8'h48;
  localparam logic [7:0] ADR_MASK     = 8'h6e;
  localparam logic [7:0] IO_OFFSET    = 8'h20;
  localparam logic [7:0] IO_LIMIT     = 8'h3f;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam int         BIT_TOV      = 0;
  localparam int         BIT_CMPA     = 1;
  localparam int         BIT_CMPB     = 2;
  localparam int         BIT_HOLD     = 7;
  localparam int         BIT_PSR_ASY  = 1;
  localparam int         BIT_PSR_SYNC = 0;
  localparam logic [7:0] FLAG_MASK    = 8'h07;
  localparam logic [7:0] GT_MASK      = 8'h83;
  localparam logic [7:0] CTRL_A_MASK  = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK  = 8'h0f;
  localparam logic [10:0] PSC_RST     = 11'h000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr0_bus_t;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [7:0]  gtctrl;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  count;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [7:0]  cmp_a_buf;
    logic [7:0]  cmp_b_buf;
    logic [10:0] psc;
    logic        down;
    logic        block;
    logic        out_a;
    logic        out_b;
    logic [7:0]  rdata;
    logic [2:0]  irq;
  } tmr0_state_t;
endpackage

/* File: hw/tmr0_regs.sv */
// Timer0 register block with shared synchronous prescaler and compare outputs
`timescale 1ns/10ps
module tmr0_regs
  import tmr0_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       I_CLOCK,
  input  wire logic       I_SRST,
  input  wire logic       I_CE,
  // CPU data bus
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_IO_SPACE,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  output logic      [7:0] O_RDATA,
  // Interrupt handshake with the core
  input  wire logic       I_GLOBAL_IE,
  input  wire logic [2:0] I_IRQ_ACK,
  output logic      [2:0] O_IRQ,
  // Waveform outputs
  output logic            O_COMPARE_OUT_A,
  output logic            O_COMPARE_OUT_B,
  // Prescaler reset seen by timers 1 and 3
  output logic            O_SYNC_PSC_RESET,
  output logic            O_ASYNC_PSC_RESET
);
  tmr0_state_t s_q;
  tmr0_state_t s_d;
  tmr0_bus_t   bus;
  logic [7:0]  dadr;
  logic [2:0]  wgm;
  logic [2:0]  cs;
  logic [7:0]  top;
  logic        tick;
  logic        pwm;
  logic        phase;
  logic        match_a;
  logic        match_b;
  logic        ovf;
  logic [7:0]  nxt;
  logic [7:0]  set_f;
  logic [7:0]  clr_f;
  logic        psr_active;

  // I/O-space accesses up to 0x3f see the register at its data offset minus 0x20
  always_comb begin
    bus.wr    = I_WR;
    bus.rd    = I_RD;
    bus.wdata = I_WDATA;
    bus.addr  = I_ADDR;
    dadr      = I_ADDR;
    if (I_IO_SPACE) begin
      dadr = (I_ADDR <= IO_LIMIT) ? I_ADDR + IO_OFFSET : 8'hff; // R2
    end
  end

  assign wgm   = {s_q.ctrl_b[3], s_q.ctrl_a[1:0]};
  assign cs    = s_q.ctrl_b[2:0];
  assign pwm   = (wgm == 3'd1) || (wgm == 3'd3) || (wgm == 3'd5) || (wgm == 3'd7);
  assign phase = (wgm == 3'd1) || (wgm == 3'd5);
  assign top   = (wgm == 3'd2 || wgm == 3'd5 || wgm == 3'd7) ? s_q.cmp_a : CNT_MAX;
  assign psr_active = s_q.gtctrl[BIT_PSR_SYNC];

  // Timer clock enable taken from the shared prescaler taps
  always_comb begin
    unique case (cs)
      3'd0: tick = 1'b0;
      3'd1: tick = 1'b1;
      3'd2: tick = (s_q.psc[2:0] == 3'h7);
      3'd3: tick = (s_q.psc[5:0] == 6'h3f);
      3'd4: tick = (s_q.psc[7:0] == 8'hff);
      3'd5: tick = (s_q.psc[9:0] == 10'h3ff);
      default: tick = 1'b0;
    endcase
    if (psr_active) begin
      tick = (cs == 3'd1);
    end
  end

  assign match_a = tick && !s_q.block && (s_q.count == s_q.cmp_a); // R8 R7
  assign match_b = tick && !s_q.block && (s_q.count == s_q.cmp_b); // R9 R7

  // Next count and overflow point per waveform mode
  always_comb begin
    nxt = s_q.count + 8'h01;
    ovf = 1'b0;
    if (phase) begin
      if (s_q.down) begin
        nxt = s_q.count - 8'h01;
      end else if (s_q.count == top) begin
        nxt = s_q.count - 8'h01;
      end
      ovf = tick && (s_q.count == CNT_BOTTOM); // R15 R16
    end else begin
      if (s_q.count == top) begin
        nxt = CNT_BOTTOM;
      end
      if (wgm == 3'd7) begin
        ovf = tick && (s_q.count == top); // R16
      end else begin
        ovf = tick && (s_q.count == CNT_MAX); // R16
      end
    end
  end

  always_comb begin
    s_d   = s_q;
    set_f = 8'h00;
    clr_f = 8'h00;
    s_d.block = s_q.block && !tick;
    // Prescaler runs unless held in reset
    s_d.psc = psr_active ? PSC_RST : s_q.psc + 11'h001; // R6
    if (!s_q.gtctrl[BIT_HOLD]) begin
      s_d.gtctrl[BIT_PSR_SYNC] = 1'b0; // R6 R5
      s_d.gtctrl[BIT_PSR_ASY]  = 1'b0; // R5
    end
    if (tick) begin
      s_d.count = nxt;
      if (phase) begin
        if (s_q.count == top) begin
          s_d.down = 1'b1;
        end else if (s_q.count == CNT_BOTTOM) begin
          s_d.down = 1'b0;
        end
      end else begin
        s_d.down = 1'b0;
      end
      // Double-buffered compares load at TOP or BOTTOM in PWM modes
      if (pwm && ((phase && s_q.count == top) || (!phase && nxt == CNT_BOTTOM))) begin
        s_d.cmp_a = s_q.cmp_a_buf;
        s_d.cmp_b = s_q.cmp_b_buf;
      end
    end
    if (!pwm) begin
      s_d.cmp_a = s_q.cmp_a_buf;
      s_d.cmp_b = s_q.cmp_b_buf;
    end
    // Waveform outputs
    if (match_a) begin
      s_d.out_a = pwm ? ((phase && s_q.down) ^ s_q.ctrl_a[6]) : ~s_q.out_a ^ s_q.ctrl_a[7]; // R8
    end
    if (match_b) begin
      s_d.out_b = pwm ? ((phase && s_q.down) ^ s_q.ctrl_a[4]) : ~s_q.out_b ^ s_q.ctrl_a[5]; // R9
    end
    if (tick && pwm && !phase && nxt == CNT_BOTTOM) begin
      s_d.out_a = ~s_q.ctrl_a[6];
      s_d.out_b = ~s_q.ctrl_a[4];
    end
    if (s_q.ctrl_a[7:6] == 2'b00) begin
      s_d.out_a = 1'b0;
    end
    if (s_q.ctrl_a[5:4] == 2'b00) begin
      s_d.out_b = 1'b0;
    end
    set_f[BIT_CMPB] = match_b; // R10
    set_f[BIT_CMPA] = match_a; // R11
    set_f[BIT_TOV]  = ovf;     // R12
    clr_f[2:0] = I_IRQ_ACK; // R10 R11 R12
    s_d.rdata = s_q.rdata;
    if (bus.rd) begin
      unique case (dadr)
        ADR_FLAGS:  s_d.rdata = s_q.flags & FLAG_MASK; // R19
        ADR_GTCTRL: s_d.rdata = s_q.gtctrl & GT_MASK;
        ADR_CTRL_A: s_d.rdata = s_q.ctrl_a;
        ADR_CTRL_B: s_d.rdata = s_q.ctrl_b & CTRL_B_MASK;
        ADR_COUNT:  s_d.rdata = s_q.count; // R7
        ADR_CMP_A:  s_d.rdata = s_q.cmp_a_buf;
        ADR_CMP_B:  s_d.rdata = s_q.cmp_b_buf;
        ADR_MASK:   s_d.rdata = s_q.mask & FLAG_MASK; // R17
        default:    s_d.rdata = RST_BYTE;
      endcase
    end
    if (bus.wr) begin
      unique case (dadr)
        ADR_FLAGS:  clr_f = clr_f | (bus.wdata & FLAG_MASK); // R18
        ADR_GTCTRL: begin
          s_d.gtctrl = bus.wdata & GT_MASK; // R4 R19
          if (!bus.wdata[BIT_HOLD]) begin
            s_d.gtctrl[BIT_PSR_ASY] = 1'b0; // R5
          end
        end
        ADR_CTRL_A: s_d.ctrl_a = bus.wdata & CTRL_A_MASK;
        ADR_CTRL_B: begin
          s_d.ctrl_b = bus.wdata & CTRL_B_MASK;
          if (!pwm && bus.wdata[7]) begin
            s_d.out_a = ~s_q.out_a ^ s_q.ctrl_a[7];
          end
          if (!pwm && bus.wdata[6]) begin
            s_d.out_b = ~s_q.out_b ^ s_q.ctrl_a[5];
          end
        end
        ADR_COUNT: begin
          s_d.count = bus.wdata; // R7
          s_d.block = 1'b1;      // R7
        end
        ADR_CMP_A:  s_d.cmp_a_buf = bus.wdata;
        ADR_CMP_B:  s_d.cmp_b_buf = bus.wdata;
        ADR_MASK:   s_d.mask = bus.wdata & FLAG_MASK; // R17 R19
        default:    s_d.rdata = s_d.rdata;
      endcase
    end
    s_d.flags = ((s_q.flags & ~clr_f) | set_f) & FLAG_MASK; // R18
    s_d.irq[BIT_TOV]  = I_GLOBAL_IE && s_q.mask[BIT_TOV] && s_q.flags[BIT_TOV];    // R1
    s_d.irq[BIT_CMPA] = I_GLOBAL_IE && s_q.mask[BIT_CMPA] && s_q.flags[BIT_CMPA]; // R14
    s_d.irq[BIT_CMPB] = I_GLOBAL_IE && s_q.mask[BIT_CMPB] && s_q.flags[BIT_CMPB]; // R13
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      s_q <= '0;
    end else if (I_CE) begin
      s_q <= s_d;
    end
  end

  assign O_RDATA           = s_q.rdata;
  assign O_IRQ             = s_q.irq;
  assign O_COMPARE_OUT_A   = s_q.out_a;
  assign O_COMPARE_OUT_B   = s_q.out_b;
  assign O_SYNC_PSC_RESET  = s_q.gtctrl[BIT_PSR_SYNC];
  assign O_ASYNC_PSC_RESET = s_q.gtctrl[BIT_PSR_ASY];
endmodule

/* File: testbench/tmr0_regs_properties.sv */
// Port-level assertions for the timer0 register block
`timescale 1ns/10ps
module tmr0_regs_properties
  import tmr0_pkg::*;
(
  // Inputs and outputs of the block
  input wire logic       I_CLOCK,
  input wire logic       I_SRST,
  input wire logic       I_CE,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic       I_IO_SPACE,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic [7:0] O_RDATA,
  input wire logic       I_GLOBAL_IE,
  input wire logic [2:0] I_IRQ_ACK,
  input wire logic [2:0] O_IRQ,
  input wire logic       O_COMPARE_OUT_A,
  input wire logic       O_COMPARE_OUT_B,
  input wire logic       O_SYNC_PSC_RESET,
  input wire logic       O_ASYNC_PSC_RESET
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  logic gt_wr;
  assign gt_wr = I_CE && I_WR && !I_IO_SPACE && I_ADDR == ADR_GTCTRL;
  ovf_irq_gate_a: assert property (I_CE && !I_GLOBAL_IE |=> !O_IRQ[0])
    else $error("overflow request without global enable");
  cmpb_irq_gate_a: assert property (I_CE && !I_GLOBAL_IE |=> !O_IRQ[2])
    else $error("compare B request without global enable");
  cmpa_irq_gate_a: assert property (I_CE && !I_GLOBAL_IE |=> !O_IRQ[1])
    else $error("compare A request without global enable");
  sync_self_clear_a: assert property (gt_wr && I_WDATA[0] && !I_WDATA[7]
    |=> O_SYNC_PSC_RESET ##1 !O_SYNC_PSC_RESET) else $error("sync reset not cleared");
  hold_keeps_a: assert property (gt_wr && I_WDATA[7] |=> O_SYNC_PSC_RESET == $past(I_WDATA[0])
    ##1 $stable(O_SYNC_PSC_RESET) && $stable(O_ASYNC_PSC_RESET)) else $error("hold lost");
  hold_release_a: assert property (gt_wr && !I_WDATA[7] |=> !O_ASYNC_PSC_RESET)
    else $error("async reset kept after hold release");
  io_limit_a: assert property (I_CE && I_RD && I_IO_SPACE && I_ADDR > IO_LIMIT
    |=> O_RDATA == RST_BYTE) else $error("io read above limit not zero");
  flag_pad_a: assert property (I_CE && I_RD && !I_IO_SPACE && I_ADDR == ADR_FLAGS
    |=> (O_RDATA & ~FLAG_MASK) == 8'h00) else $error("unused flag bits set");
  cover property (gt_wr && I_WDATA[7]);
  cover property (O_IRQ[1] && I_IRQ_ACK[1]);
  cover property (I_RD && I_IO_SPACE && I_ADDR > IO_LIMIT);
endmodule
bind tmr0_regs tmr0_regs_properties i_tmr0_regs_properties (.*);

/* File: testbench/tmr0_cpu_model.sv */
// Core model: executes one pending vector at a time when enabled
`timescale 1ns/10ps
module tmr0_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_en,
  input  wire logic [2:0] i_irq,
  output logic      [2:0] o_ack
);
  logic [1:0] gap_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_en) begin
      o_ack <= 3'h0;
      gap_q <= 2'h0;
    end else if (gap_q != 2'h0) begin
      o_ack <= 3'h0;
      gap_q <= gap_q - 2'h1;
    end else if (i_irq != 3'h0) begin
      o_ack <= i_irq & (~i_irq + 3'h1);
      gap_q <= 2'h3;
    end
  end
endmodule

/* File: testbench/tb_tmr0_regs.sv */
// Testbench for the timer0 register block
`timescale 1ns/10ps
module tb_tmr0_regs
  import tmr0_pkg::*;
;
  logic clk, srst, wr, rd, io, gie, en, osy, oas, oa, ob, ce;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] ack, irq;
  logic [15:0] seed;
  int errors, compares, mdl[int];
  logic [7:0] regs[8] = '{ADR_FLAGS, ADR_GTCTRL, ADR_CTRL_A, ADR_CTRL_B, ADR_COUNT,
                          ADR_CMP_A, ADR_CMP_B, ADR_MASK};
  tmr0_regs i_tmr0_regs (.I_CLOCK(clk), .I_SRST(srst), .I_CE(ce), .I_WR(wr), .I_RD(rd),
    .I_IO_SPACE(io), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .I_GLOBAL_IE(gie),
    .I_IRQ_ACK(ack), .O_IRQ(irq), .O_COMPARE_OUT_A(oa), .O_COMPARE_OUT_B(ob),
    .O_SYNC_PSC_RESET(osy), .O_ASYNC_PSC_RESET(oas));
  tmr0_cpu_model i_tmr0_cpu_model (.i_clk(clk), .i_rst(srst), .i_en(en), .i_irq(irq),
    .o_ack(ack));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w; rd <= !w; io <= s; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic s, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, s, a, 8'h00);
    chk(rdata, e);
  endtask
  task automatic poll(input logic [7:0] e);
    int n;
    for (n = 0; n < 200 && rdata !== e; n++) acc(1'b0, 1'b0, ADR_FLAGS, 8'h00);
    if (n == 200) begin
      errors++;
      wrap_up();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    logic [7:0] a;
    srst = 1'b1; wr = 1'b0; rd = 1'b0; io = 1'b0; addr = 8'h00; wdata = 8'h00;
    gie = 1'b0; en = 1'b0; seed = 16'ha48f; ce = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    foreach (regs[i]) rchk(1'b0, regs[i], RST_BYTE);
    for (int i = 0; i < 6; i++) begin
      a = ADR_COUNT + 8'(i % 3);
      seed = lfsr(seed);
      mdl[a] = seed[7:0];
      acc(1'b1, i[0], i[0] ? a - IO_OFFSET : a, seed[7:0]);
      rchk(!i[0], i[0] ? a : a - IO_OFFSET, 8'(mdl[a]));
    end
    acc(1'b1, 1'b0, ADR_MASK, 8'h05);
    acc(1'b1, 1'b1, ADR_MASK - IO_OFFSET, 8'h00);
    rchk(1'b1, ADR_MASK - IO_OFFSET, RST_BYTE);
    rchk(1'b0, ADR_MASK, 8'h05);
    acc(1'b1, 1'b0, ADR_GTCTRL, 8'hff);
    rchk(1'b0, ADR_GTCTRL, GT_MASK);
    chk({6'h0, oas, osy}, 8'h03);
    acc(1'b1, 1'b0, ADR_GTCTRL, 8'h00);
    chk({6'h0, oas, osy}, 8'h00);
    acc(1'b1, 1'b0, ADR_GTCTRL, 8'h01);
    rchk(1'b0, ADR_GTCTRL, 8'h00);
    acc(1'b1, 1'b0, ADR_COUNT, 8'hf0);
    acc(1'b1, 1'b0, ADR_CMP_A, 8'hf8);
    acc(1'b1, 1'b0, ADR_CMP_B, 8'h10);
    acc(1'b1, 1'b0, ADR_MASK, 8'h07);
    acc(1'b1, 1'b0, ADR_CTRL_B, 8'h01);
    poll(8'h07);
    acc(1'b1, 1'b0, ADR_CTRL_B, 8'h00);
    rchk(1'b0, ADR_FLAGS, 8'h07);
    chk({5'h0, irq}, 8'h00);
    acc(1'b1, 1'b0, ADR_FLAGS, 8'h00);
    rchk(1'b0, ADR_FLAGS, 8'h07);
    acc(1'b1, 1'b0, ADR_FLAGS, 8'hf9);
    rchk(1'b0, ADR_FLAGS, 8'h06);
    @(posedge clk);
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({5'h0, irq}, 8'h06);
    en <= 1'b1;
    poll(8'h00);
    rchk(1'b0, ADR_FLAGS, 8'h00);
    // A write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    acc(1'b1, 1'b0, ADR_MASK, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rchk(1'b0, ADR_MASK, 8'h07);
    wrap_up();
  end
endmodule
